// [common/supervisor_pkg.sv]
// Constants, carrier structs and a helper function for the output fault
// supervisor. Assumes a single 10 MHz clock and eight low-side outputs.
//
// Functional notes
// - Open-load is judged for an output only while its command bit is low.
// - Every output has its own comparator result, judged bit by bit.
// - Pull-down sources come up enabled after reset.
// - Open-load bit reads 0 while that output's pull-down is off.
// - Pull-downs turn off only in sleep or when the serial disable asks.
// - Open-load filter delay lies between 100 and 450 microseconds.
// - Chip-select rising edge restarts the filter; compare only after expiry.
// - A vanished open-load stays latched until the response is read; turning its pull-down off clears it too.
// - Logic-supply under-voltage turns outputs off and resets control state.
// - Battery under-voltage turns outputs off and resets control state.
// - Low battery band: outputs follow commands, status flagged not valid.
// - Battery over-voltage holds outputs off until the supply is normal.
// - Calibration flag in the response reads 1 trimmed, 0 untrimmed.
// - Fault bits read 1 for fault and 0 for no fault.

package supervisor_pkg;

	// -----------------------------------------------------------------
	// Sizes and timing
	// -----------------------------------------------------------------
	localparam int     NUM_OUT       = 8;
	localparam int     CLK_HZ        = 10_000_000;
	localparam int     FILTER_MIN_US = 100;
	localparam int     FILTER_MAX_US = 450;
	// The least delay rounds up to whole cycles.
	localparam longint FILTER_CYC    =
		(longint'(FILTER_MIN_US) * CLK_HZ + 999_999) / 1_000_000;
	localparam int     CNT_W         = 10;
	localparam logic [CNT_W-1:0] FILTER_LOAD = CNT_W'(FILTER_CYC - 1);
	localparam logic [CNT_W-1:0] CNT_ZERO    = 10'h000;

	// -----------------------------------------------------------------
	// Reset values
	// -----------------------------------------------------------------
	localparam logic [NUM_OUT-1:0] GATE_RST  = 8'h00;
	localparam logic [NUM_OUT-1:0] PD_RST    = 8'hff;
	localparam logic [NUM_OUT-1:0] FAULT_RST = 8'h00;

	typedef enum logic [1:0] {
		RUN,
		UV_SHUT,
		OV_SHUT
	} supply_mode_type;

	// -----------------------------------------------------------------
	// Carriers
	// -----------------------------------------------------------------
	typedef struct packed {
		logic               cs_b;
		logic [NUM_OUT-1:0] cmp;
		logic               vdd_uv;
		logic               batt_uv;
		logic               batt_ov;
		logic               batt_low;
		logic               trimmed;
	} pin_type;

	localparam int PIN_W = $bits(pin_type);

	// Chip select idles high; every other pin flag idles low.
	localparam pin_type PIN_RST = '{
		cs_b:     1'b1,
		cmp:      FAULT_RST,
		vdd_uv:   1'b0,
		batt_uv:  1'b0,
		batt_ov:  1'b0,
		batt_low: 1'b0,
		trimmed:  1'b0
	};

	typedef struct packed {
		supply_mode_type    mode;
		logic               cs_prev;
		logic [NUM_OUT-1:0] gate;
		logic [NUM_OUT-1:0] pulldown_en;
		logic [NUM_OUT-1:0] open_fault;
		logic               ov_fault;
		logic               trim_set;
		logic               status_valid;
		logic               ctrl_reset;
	} state_type;

	localparam state_type STATE_RST = '{
		mode:         RUN,
		cs_prev:      1'b1,
		gate:         GATE_RST,
		pulldown_en:  PD_RST,
		open_fault:   FAULT_RST,
		ov_fault:     1'b0,
		trim_set:     1'b0,
		status_valid: 1'b0,
		ctrl_reset:   1'b1
	};

	// Sticky fault: a new event wins over a clear in the same cycle.
	function automatic logic [NUM_OUT-1:0] fault_hold(
		input logic [NUM_OUT-1:0] prev,
		input logic [NUM_OUT-1:0] set,
		input logic               clr
	);
		fault_hold = set | (prev & ~{NUM_OUT{clr}});
	endfunction : fault_hold

endpackage : supervisor_pkg

// [hw/pin_sync.sv]
// Two-stage synchroniser for the supervisor's asynchronous pin inputs.
// Assumes a reset already released in step with clk_in.
`timescale 1ns/1ns
`default_nettype none

module pin_sync #(
	parameter int               WIDTH   = supervisor_pkg::PIN_W,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input  wire logic             clk_in,
	input  wire logic             rst_b_in,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_reg;

	// Only the second stage is visible to the rest of the design.
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			meta_reg <= RST_VAL;
			sync_out <= RST_VAL;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end

endmodule : pin_sync

`default_nettype wire

// [hw/filter_timer.sv]
// Open-load fault delay timer, restarted by a one-cycle pulse.
// Assumes a reset already released in step with clk_in.
`timescale 1ns/1ns
`default_nettype none

module filter_timer (
	input  wire logic clk_in,
	input  wire logic rst_b_in,
	input  wire logic restart_in,
	output logic      expired_out
);

	logic [supervisor_pkg::CNT_W-1:0] count_reg;

	// The timer starts loaded so no fault is taken right after reset.
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			count_reg <= supervisor_pkg::FILTER_LOAD;
		end else if (restart_in) begin
			count_reg <= supervisor_pkg::FILTER_LOAD;
		end else if (count_reg != supervisor_pkg::CNT_ZERO) begin
			count_reg <= count_reg - 1'b1;
		end
	end

	assign expired_out = (count_reg == supervisor_pkg::CNT_ZERO);

endmodule : filter_timer

`default_nettype wire

// [hw/output_fault_supervisor.sv]
// Fault supervisor of an eight-channel low-side driver: open-load checks,
// supply shutdown and latched status for the serial response word.
// Assumes command and disable bits come from the serial block on clk_in,
// while comparator, supply and chip-select levels arrive asynchronously.
`timescale 1ns/1ns
`default_nettype none

module output_fault_supervisor (
	input  wire logic                              clk_in,
	input  wire logic                              rst_b_in,
	input  wire logic                              cs_b_in,
	input  wire logic [supervisor_pkg::NUM_OUT-1:0] out_cmd_in,
	input  wire logic [supervisor_pkg::NUM_OUT-1:0] pulldown_dis_in,
	input  wire logic                              sleep_in,
	input  wire logic                              frame_done_in,
	input  wire logic [supervisor_pkg::NUM_OUT-1:0] open_cmp_in,
	input  wire logic                              vdd_uv_in,
	input  wire logic                              batt_uv_in,
	input  wire logic                              batt_ov_in,
	input  wire logic                              batt_low_in,
	input  wire logic                              trimmed_in,
	output logic      [supervisor_pkg::NUM_OUT-1:0] gate_out,
	output logic      [supervisor_pkg::NUM_OUT-1:0] pulldown_en_out,
	output logic      [supervisor_pkg::NUM_OUT-1:0] open_fault_out,
	output logic                                   ov_fault_out,
	output logic                                   trim_set_out,
	output logic                                   status_valid_out,
	output logic                                   ctrl_reset_out
);

	// -----------------------------------------------------------------
	// Reset release
	// -----------------------------------------------------------------
	logic [1:0] rst_sync_reg;
	logic       rst_b;

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rst_sync_reg <= 2'h0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end

	assign rst_b = rst_sync_reg[1];

	// -----------------------------------------------------------------
	// Pin synchronisation and filter timer
	// -----------------------------------------------------------------
	supervisor_pkg::pin_type   pin_raw;
	supervisor_pkg::pin_type   pin;
	supervisor_pkg::state_type st_reg;
	supervisor_pkg::state_type st_next;
	logic                      cs_rise;
	logic                      filter_done;
	logic                      any_uv;
	logic [supervisor_pkg::NUM_OUT-1:0] detect;
	logic [supervisor_pkg::NUM_OUT-1:0] ov_hold;

	assign pin_raw = '{
		cs_b:     cs_b_in,
		cmp:      open_cmp_in,
		vdd_uv:   vdd_uv_in,
		batt_uv:  batt_uv_in,
		batt_ov:  batt_ov_in,
		batt_low: batt_low_in,
		trimmed:  trimmed_in
	};

	// Chip select resets to its idle high level, so that the edge
	// detector sees no false rising edge as reset lets go.
	pin_sync #(
		.WIDTH  (supervisor_pkg::PIN_W),
		.RST_VAL(supervisor_pkg::PIN_RST)
	) u_pin_sync (
		.clk_in  (clk_in),
		.rst_b_in(rst_b),
		.async_in(pin_raw),
		.sync_out(pin)
	);

	assign cs_rise = pin.cs_b & ~st_reg.cs_prev;

	filter_timer u_filter_timer (
		.clk_in     (clk_in),
		.rst_b_in   (rst_b),
		.restart_in (cs_rise),
		.expired_out(filter_done)
	);

	assign any_uv = pin.vdd_uv | pin.batt_uv;

	// -----------------------------------------------------------------
	// Next state
	// -----------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		st_next.cs_prev = pin.cs_b;

		// Under-voltage outranks over-voltage: both switch off, but only
		// under-voltage also wipes the control state.
		if (any_uv) begin
			st_next.mode = supervisor_pkg::UV_SHUT;
		end else if (pin.batt_ov) begin
			st_next.mode = supervisor_pkg::OV_SHUT;
		end else begin
			st_next.mode = supervisor_pkg::RUN;
		end

		case (st_next.mode)
			supervisor_pkg::RUN: begin
				st_next.gate = out_cmd_in;
				st_next.ctrl_reset = 1'b0;
				st_next.pulldown_en = ~(pulldown_dis_in |
					{supervisor_pkg::NUM_OUT{sleep_in}});
			end
			supervisor_pkg::OV_SHUT: begin
				st_next.gate = supervisor_pkg::GATE_RST;
				st_next.ctrl_reset = 1'b0;
				st_next.pulldown_en = ~(pulldown_dis_in |
					{supervisor_pkg::NUM_OUT{sleep_in}});
			end
			default: begin
				// The serial disable is a control bit and is held in reset.
				st_next.gate = supervisor_pkg::GATE_RST;
				st_next.ctrl_reset = 1'b1;
				st_next.pulldown_en = supervisor_pkg::PD_RST &
					~{supervisor_pkg::NUM_OUT{sleep_in}};
			end
		endcase

		st_next.open_fault = supervisor_pkg::fault_hold(st_reg.open_fault,
			detect, frame_done_in) & st_next.pulldown_en;
		// The over-voltage flag shares the sticky helper on bit 0 only.
		ov_hold = supervisor_pkg::fault_hold({7'h00, st_reg.ov_fault},
			{7'h00, pin.batt_ov}, frame_done_in);
		st_next.ov_fault = ov_hold[0];
		st_next.trim_set = pin.trimmed;
		// Status in the low battery band is flagged, not suppressed.
		st_next.status_valid = ~pin.batt_low & ~any_uv;
	end

	// Judged only when off, pulled down, filtered and free of under- and over-voltage.
	always_comb begin
		detect = pin.cmp & ~out_cmd_in & st_reg.pulldown_en;
		if (!filter_done || st_reg.mode != supervisor_pkg::RUN) begin
			detect = supervisor_pkg::FAULT_RST;
		end
	end

	// -----------------------------------------------------------------
	// State register
	// -----------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rst_b) begin
		if (!rst_b) begin
			st_reg <= supervisor_pkg::STATE_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	assign gate_out         = st_reg.gate;
	assign pulldown_en_out  = st_reg.pulldown_en;
	assign open_fault_out   = st_reg.open_fault;
	assign ov_fault_out     = st_reg.ov_fault;
	assign trim_set_out     = st_reg.trim_set;
	assign status_valid_out = st_reg.status_valid;
	assign ctrl_reset_out   = st_reg.ctrl_reset;

	// -----------------------------------------------------------------
	// Assertions
	// -----------------------------------------------------------------
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_b);

	sequence cs_edge_seq;
		pin.cs_b && !st_reg.cs_prev;
	endsequence

	sequence no_new_fault_seq;
		(open_fault_out & ~$past(open_fault_out)) == 8'h00;
	endsequence

	a_uv_gate_off: assert property (
		any_uv |=> gate_out == 8'h00 && ctrl_reset_out)
		else $error("gates not off after under-voltage");

	a_batt_uv_reset: assert property (
		pin.batt_uv && !pin.vdd_uv |=> ctrl_reset_out && gate_out == 8'h00)
		else $error("battery under-voltage did not reset control");

	a_ov_gate_off: assert property (
		pin.batt_ov |=> gate_out == 8'h00 && !ctrl_reset_out ||
			$past(any_uv))
		else $error("gates not off during over-voltage");

	a_gate_follows_cmd: assert property (
		!any_uv && !pin.batt_ov |=> gate_out == $past(out_cmd_in))
		else $error("gates do not follow the command word");

	a_pd_fault_zero: assert property (
		(open_fault_out & ~pulldown_en_out) == 8'h00)
		else $error("fault reported with pull-down off");

	a_pd_stays_on: assert property (
		!sleep_in && pulldown_dis_in == 8'h00 |=> pulldown_en_out == 8'hff)
		else $error("pull-down off without sleep or disable");

	a_fault_only_off: assert property (
		((open_fault_out & ~$past(open_fault_out)) &
			$past(out_cmd_in)) == 8'h00)
		else $error("open load raised on a commanded-on output");

	a_filter_masks: assert property (
		cs_edge_seq |-> ##2 no_new_fault_seq [*8])
		else $error("fault taken before the filter expired");

	a_fault_latched: assert property (
		!frame_done_in && !sleep_in |=> ($past(open_fault_out) &
			~$past(pulldown_dis_in) & ~open_fault_out) == 8'h00)
		else $error("latched fault lost before it was read");

	a_read_clears: assert property (
		frame_done_in |=>
			(open_fault_out & ~$past(detect)) == 8'h00)
		else $error("fault not cleared after being read");

	a_trim_flag: assert property (
		pin.trimmed ##1 pin.trimmed |=> trim_set_out)
		else $error("trim flag not reported");

	a_low_band_flag: assert property (
		pin.batt_low |=> !status_valid_out)
		else $error("status claimed valid in low battery band");

	// -----------------------------------------------------------------
	// Assertions: supplies, pull-downs and status flags
	// -----------------------------------------------------------------
	// Read-out and supply steps, each used by one property below.
	sequence ov_read_seq;
		frame_done_in && !pin.batt_ov;
	endsequence

	sequence uv_entry_seq;
		any_uv && !sleep_in;
	endsequence

	a_uv_ctrl_free: assert property (
		!any_uv |=> !ctrl_reset_out)
		else $error("control held in reset with supplies normal");

	a_uv_pd_reset: assert property (
		uv_entry_seq |=> pulldown_en_out == 8'hff)
		else $error("pull-downs not at reset value in under-voltage");

	a_ov_flag_set: assert property (
		pin.batt_ov |=> ov_fault_out)
		else $error("over-voltage not flagged");

	a_ov_flag_hold: assert property (
		ov_fault_out && !frame_done_in |=> ov_fault_out)
		else $error("over-voltage flag lost before it was read");

	a_ov_flag_clear: assert property (
		ov_read_seq |=> !ov_fault_out)
		else $error("over-voltage flag not cleared after being read");

	a_sleep_pd_off: assert property (
		sleep_in |=> pulldown_en_out == 8'h00)
		else $error("pull-downs left on in sleep");

	a_dis_pd_off: assert property (
		!any_uv && pulldown_dis_in != 8'h00 |=>
			(pulldown_en_out & $past(pulldown_dis_in)) == 8'h00)
		else $error("disabled pull-down left on");

	a_dis_fault_zero: assert property (
		!any_uv && pulldown_dis_in != 8'h00 |=>
			(open_fault_out & $past(pulldown_dis_in)) == 8'h00)
		else $error("fault kept on an output with its pull-down off");

	a_trim_clear: assert property (
		!pin.trimmed |=> !trim_set_out)
		else $error("trim flag set while untrimmed");

	a_valid_normal: assert property (
		!pin.batt_low && !any_uv |=> status_valid_out)
		else $error("status not valid with a normal supply");

	// -----------------------------------------------------------------
	// Assertions: filter timer and fault capture
	// -----------------------------------------------------------------
	// The reload is visible one cycle after the synced chip-select edge.
	a_timer_restart: assert property (
		cs_edge_seq |=> !filter_done)
		else $error("filter timer not restarted by chip select");

	a_detect_gated: assert property (
		!filter_done |-> detect == 8'h00)
		else $error("comparator taken while the filter runs");

	// A fault judged now must show in the next word with pull-downs on.
	a_fault_set: assert property (
		detect != 8'h00 && !sleep_in && pulldown_dis_in == 8'h00 |=>
			(open_fault_out & $past(detect)) == $past(detect))
		else $error("judged open load not latched");

endmodule : output_fault_supervisor

`default_nettype wire

// [verif/mcu_model.sv]
// Microcontroller side of the supervisor: chip select, command word and
// the pulse that marks the response word as shifted out.
// Assumes the bench calls frame() from its falling-edge sequence.
`timescale 1ns/1ns
`default_nettype none

module mcu_model (
	input  wire logic       clk_in,
	output logic            cs_b_out,
	output logic      [7:0] cmd_out,
	output logic            done_out
);
	initial begin
		cs_b_out = 1'b1;
		cmd_out  = 8'h00;
		done_out = 1'b0;
	end

	// -----------------------------------------------------------------
	// One frame
	// -----------------------------------------------------------------
	// The response is read out while chip select is still low, so the
	// clear lands before the rising edge restarts the filter timer.
	task automatic frame(input logic [7:0] cmd);
		@(negedge clk_in);
		cs_b_out = 1'b0;
		cmd_out  = cmd;
		repeat (16) @(negedge clk_in);
		done_out = 1'b1;
		@(negedge clk_in);
		done_out = 1'b0;
		cs_b_out = 1'b1;
	endtask : frame
endmodule : mcu_model
`default_nettype wire

// [verif/output_fault_supervisor_tb.sv]
// Self-checking bench for the output fault supervisor.
// Assumes a 10 MHz clock and the fixed 1000-cycle open-load filter.
`timescale 1ns/1ns
`default_nettype none

module output_fault_supervisor_tb;
	logic       clk_in, rst_b_in, cs_b, done, sleep_in;
	logic [7:0] cmd, dis, cmp, gate, pd_en, open_fault;
	logic       vdd_uv, batt_uv, batt_ov, batt_low, trimmed;
	logic       ov_fault, trim_set, status_valid, ctrl_reset;
	int         mismatches  = 0;
	int         checks_done = 0;

	mcu_model mcu_u (.clk_in(clk_in), .cs_b_out(cs_b), .cmd_out(cmd),
		.done_out(done));

	output_fault_supervisor dut_u (.clk_in(clk_in), .rst_b_in(rst_b_in),
		.cs_b_in(cs_b), .out_cmd_in(cmd), .pulldown_dis_in(dis),
		.sleep_in(sleep_in), .frame_done_in(done), .open_cmp_in(cmp),
		.vdd_uv_in(vdd_uv), .batt_uv_in(batt_uv), .batt_ov_in(batt_ov),
		.batt_low_in(batt_low), .trimmed_in(trimmed), .gate_out(gate),
		.pulldown_en_out(pd_en), .open_fault_out(open_fault),
		.ov_fault_out(ov_fault), .trim_set_out(trim_set),
		.status_valid_out(status_valid), .ctrl_reset_out(ctrl_reset));

	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end

	// -----------------------------------------------------------------
	// Tasks
	// -----------------------------------------------------------------
	// Pins pass two sync flops and a state flop; four cycles cover it.
	task automatic settle();
		repeat (4) @(negedge clk_in);
	endtask : settle

	task automatic check(input string name, input logic [7:0] seen,
		input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_sim

	// -----------------------------------------------------------------
	// Tests
	// -----------------------------------------------------------------
	initial begin
		rst_b_in = 1'b0;
		dis      = 8'h00;
		cmp      = 8'h00;
		sleep_in = 1'b0;
		vdd_uv   = 1'b0;
		batt_uv  = 1'b0;
		batt_ov  = 1'b0;
		batt_low = 1'b0;
		trimmed  = 1'b0;
		repeat (5) @(negedge clk_in);
		rst_b_in = 1'b1;
		settle();
		check("gate", gate, 8'h00);
		check("pulldown", pd_en, 8'hff);
		check("open", open_fault, 8'h00);
		check("trim", 8'(trim_set), 8'h00);
		trimmed = 1'b1;
		settle();
		check("trim", 8'(trim_set), 8'h01);
		batt_low = 1'b1;
		mcu_u.frame(8'h0f);
		settle();
		check("gate", gate, 8'h0f);
		check("valid", 8'(status_valid), 8'h00);
		batt_low = 1'b0;
		// The comparators rise with the frame end, as after a switch-off.
		mcu_u.frame(8'h0f);
		cmp = 8'h5a;
		repeat (990) @(negedge clk_in);
		check("open", open_fault, 8'h00);
		check("valid", 8'(status_valid), 8'h01);
		repeat (3510) @(negedge clk_in);
		check("open", open_fault, 8'h50);
		cmp = 8'h10;
		settle();
		check("open", open_fault, 8'h50);
		mcu_u.frame(8'h0f);
		settle();
		check("open", open_fault, 8'h10);
		dis = 8'h10;
		settle();
		check("pulldown", pd_en, 8'hef);
		check("open", open_fault, 8'h00);
		sleep_in = 1'b1;
		settle();
		check("pulldown", pd_en, 8'h00);
		sleep_in = 1'b0;
		dis      = 8'h00;
		cmp      = 8'h00;
		settle();
		check("pulldown", pd_en, 8'hff);
		batt_ov = 1'b1;
		settle();
		check("gate", gate, 8'h00);
		check("ov", 8'(ov_fault), 8'h01);
		batt_ov = 1'b0;
		settle();
		check("gate", gate, 8'h0f);
		check("ov", 8'(ov_fault), 8'h01);
		mcu_u.frame(8'h0f);
		settle();
		check("ov", 8'(ov_fault), 8'h00);
		// The serial disable is a control bit: under-voltage overrides it.
		dis = 8'h01;
		for (int i = 0; i < 2; i++) begin
			if (i == 0) begin
				vdd_uv = 1'b1;
			end else begin
				batt_uv = 1'b1;
			end
			settle();
			check("gate", gate, 8'h00);
			check("ctrl", 8'(ctrl_reset), 8'h01);
			check("pulldown", pd_en, 8'hff);
			vdd_uv  = 1'b0;
			batt_uv = 1'b0;
			settle();
			check("ctrl", 8'(ctrl_reset), 8'h00);
		end
		// A reset in mid-run brings the pull-downs back on.
		rst_b_in = 1'b0;
		settle();
		check("pulldown", pd_en, 8'hff);
		check("gate", gate, 8'h00);
		rst_b_in = 1'b1;
		settle();
		check("pulldown", pd_en, 8'hfe);
		check("gate", gate, 8'h0f);
		end_sim();
	end

	// The tests take about 5000 cycles; four times that means a hang.
	initial begin
		repeat (20000) @(posedge clk_in);
		mismatches++;
		end_sim();
	end
endmodule : output_fault_supervisor_tb
`default_nettype wire
